//--- dv/tb.sv
// Purpose: register bus tests of the channel resource registers
// Assumes: AXI4-Lite master in the bench, 250 MHz clock
// Notes: expected results queued, compared on each response
`timescale 1ns/100ps
`include "vc_resource_consts.vh"
module tb;
  reg aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  reg bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg neg_p = 1'h0, tbl_wr = 1'h0;
  reg [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg [31:0] wdata = 32'h0000_0000, d;
  reg [3:0] wstrb = 4'h0;
  reg [2:0] strap = 3'h1;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer seed = 27, fail_count = 0, check_count = 0, cyc = 0, i;
  reg [33:0] q[$];
  initial forever #2 aclk = ~aclk;
  vc_resource_registers dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_channel_count(strap),
    .negotiation_pending(neg_p), .arb_table_written(tbl_wr),
    .traffic_class_channel_map(), .port_arb_select(),
    .channel_identifier(), .channel_enable(), .table_load_active(),
    .arb_capability(), .max_time_slots(), .table_offset());
  task chk(input [33:0] s, input [33:0] e);
    check_count = check_count + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task bus(input w, input [11:0] a, input [31:0] v, input [1:0] r);
    reg ta, tw, tr, dn;
    q.push_back({r, w ? 32'h0000_0000 : v});
    @(posedge aclk);
    if (w)
    begin
      awaddr <= a; wdata <= v; wstrb <= 4'hf;
      awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    end
    else
    begin
      araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    end
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready;
      tr = arvalid && arready; dn = bvalid && bready || rvalid && rready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tr) arvalid <= 1'h0;
    end
    while (!dn);
    bready <= 1'h0; rready <= 1'h0;
  endtask
  always @(posedge aclk)
    if (bvalid && bready || rvalid && rready)
      chk(bvalid && bready ? {bresp, 32'h0000_0000} : {rresp, rdata},
        q.pop_front());
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    bus(0, `OFS_CH1_CAP, 32'h087f_0019, `RESP_OKAY);
    bus(0, `OFS_CH1_CTRL, 32'h0100_0000, `RESP_OKAY);
    bus(0, `OFS_CH0_STATUS, 32'h0000_0000, `RESP_OKAY);
    neg_p <= 1'h1;
    repeat (6) @(posedge aclk);
    bus(0, `OFS_CH0_STATUS, 32'h0002_0000, `RESP_OKAY);
    neg_p <= 1'h0; tbl_wr <= 1'h1;
    @(posedge aclk);
    tbl_wr <= 1'h0;
    repeat (6) @(posedge aclk);
    bus(0, `OFS_CH0_STATUS, 32'h0001_0000, `RESP_OKAY);
    for (i = 0; i < 8; i = i + 1)
    begin
      d = $random(seed); d[19:17] = i[2:0]; d[16] = 1'h0;
      bus(1, `OFS_CH1_CTRL, d, `RESP_OKAY);
      if (!(i == 0 || i == 3 || i == 4)) d[19:17] = 3'h0;
      bus(0, `OFS_CH1_CTRL, d & 32'h870e_00fe, `RESP_OKAY);
    end
    bus(1, `OFS_CH1_CTRL, 32'h0001_0000, `RESP_OKAY);
    bus(0, `OFS_CH1_CTRL, 32'h0000_0000, `RESP_OKAY);
    bus(0, `OFS_CH0_STATUS, 32'h0001_0000, `RESP_OKAY);
    bus(0, `OFS_MGMT_CTRL, 32'h0000_0001, `RESP_OKAY);
    bus(1, `OFS_CH1_CTRL, 32'h0001_0000, `RESP_OKAY);
    repeat (55) @(posedge aclk);
    bus(0, `OFS_CH0_STATUS, 32'h0000_0000, `RESP_OKAY);
    bus(0, `OFS_MGMT_CTRL, 32'h0000_0000, `RESP_OKAY);
    bus(1, 12'h100, d, `RESP_SLVERR);
    bus(0, 12'h100, 32'h0000_0000, `RESP_SLVERR);
    bus(1, `OFS_CH1_CAP, 32'hffff_ffff, `RESP_OKAY);
    bus(0, `OFS_CH1_CAP, 32'h087f_0019, `RESP_OKAY);
    bus(1, `OFS_MGMT_DEFAULTS, 32'h0055_00ff, `RESP_OKAY);
    bus(0, `OFS_MGMT_DEFAULTS, 32'h0055_00fe, `RESP_OKAY);
    bus(0, `OFS_CH1_CAP, 32'h0855_0019, `RESP_OKAY);
    bus(0, `OFS_CH1_CTRL, 32'h0000_00fe, `RESP_OKAY);
    strap <= 3'h0; aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    bus(0, `OFS_CH1_CAP, 32'h0000_0000, `RESP_OKAY);
    bus(0, `OFS_CH1_CTRL, 32'h0000_0000, `RESP_OKAY);
    @(posedge aclk);
    finish_test;
  end
endmodule // tb

//--- dv/vc_resource_monitor.sv
// Purpose: checks on the channel resource register outputs
// Assumes: one clock, synchronous active low reset
// Notes: bound into vc_resource_registers
`timescale 1ns/100ps
`include "vc_resource_consts.vh"
module vc_resource_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] ext_channel_count,
  input wire [7:0] traffic_class_channel_map,
  input wire [2:0] port_arb_select,
  input wire [2:0] channel_identifier,
  input wire channel_enable,
  input wire table_load_active,
  input wire [7:0] arb_capability,
  input wire [7:0] table_offset
);
  reg [7:0] cnt_r;
  wire [7:0] cnt_nxt = table_load_active ? cnt_r + 8'h01 : 8'h00;
  wire strap_one = ext_channel_count == 3'h1;
  always @(posedge aclk)
    cnt_r <= aresetn ? cnt_nxt : 8'h00;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_shown;
    s_axi_rvalid;
  endsequence
  a_map_bit_zero:
    assert property (traffic_class_channel_map[0] == 1'h0)
    else $error("map bit 0 set");
  a_arb_sel_legal:
    assert property (port_arb_select inside {`ARB_SEL_FIXED,
      `ARB_SEL_WRR, `ARB_SEL_TIME_WRR}) else $error("bad select");
  a_tbl_ofs_tie:
    assert property (table_offset == (arb_capability == `CAP_ARB_CH_ON ?
      `CAP_TBL_OFS_ON : `CAP_TBL_OFS_OFF)) else $error("bad offset");
  a_load_len:
    assert property ($fell(table_load_active) |-> cnt_r == `LOAD_CYCLES)
    else $error("load length wrong");
  a_rd_answer:
    assert property (s_ar_taken |=> s_r_shown) else $error("no read data");
  a_r_one_beat:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_rst_values:
    assert property (!$past(aresetn) |-> !channel_enable &&
      channel_identifier == 3'h0 && traffic_class_channel_map == 8'h00)
    else $error("bad reset value");
  a_strap_latch:
    assert property ($rose(aresetn) |=> arb_capability == ($past(strap_one)
      ? `CAP_ARB_CH_ON : `CAP_ARB_CH_OFF) && channel_identifier ==
      ($past(strap_one) ? `CHAN_ID_ON : `CHAN_ID_OFF)) else $error("strap");
endmodule // vc_resource_monitor
bind vc_resource_registers vc_resource_monitor u_mon (.aclk(aclk),
  .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .ext_channel_count(ext_channel_count),
  .traffic_class_channel_map(traffic_class_channel_map),
  .port_arb_select(port_arb_select),
  .channel_identifier(channel_identifier),
  .channel_enable(channel_enable), .table_load_active(table_load_active),
  .arb_capability(arb_capability), .table_offset(table_offset));

//--- rtl/vc_resource_consts.vh
// Purpose: constants for the channel resource register slice
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: reset values depending on the extended channel count strap
`ifndef VC_RESOURCE_CONSTS_VH
`define VC_RESOURCE_CONSTS_VH

`define OFS_CH0_STATUS 12'h158
`define OFS_CH1_CAP 12'h15c
`define OFS_CH1_CTRL 12'h160
`define OFS_TABLE_PORT 12'h170
`define OFS_MGMT_CTRL 12'h174
`define OFS_MGMT_DEFAULTS 12'h178

`define BIT_TABLE_STATUS 16
`define BIT_NEG_PENDING 17
`define BIT_LOAD_TABLE 16
`define BIT_CH_ENABLE 31
`define BIT_MGMT_LOAD 0
`define BIT_MGMT_NEG_DONE 1

`define CAP_ARB_CH_OFF 8'h00
`define CAP_ARB_CH_ON 8'h19
`define CAP_SLOTS_CH_OFF 7'h00
`define CAP_SLOTS_CH_ON 7'h7f
`define CAP_TBL_OFS_OFF 8'h00
`define CAP_TBL_OFS_ON 8'h08
`define CHAN_ID_OFF 3'h0
`define CHAN_ID_ON 3'h1
`define TC_MAP_RESET 8'h00
`define ARB_SEL_FIXED 3'h0
`define ARB_SEL_WRR 3'h3
`define ARB_SEL_TIME_WRR 3'h4

`define LOAD_CYCLES 8'h40

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/vc_resource_registers.v
// Purpose: second channel resource registers and first channel status
// Assumes: AXI4-Lite slave, one clock, synchronous active low reset
// Notes: strap is the low bits of the extended channel count register
//
// Notes on behaviour
// - any write of a port arbitration table entry sets the table status
// - table status clears when the table copy into the arbiter finishes
// - negotiation pending reads high while negotiating, reset zero
// - arbitration capability resets 00h or 19h by channel count strap
// - round robin, weighted and time weighted; time scheme on channel one
// - max time slots resets 00h or 7Fh, management may override
// - table offset in sixteen byte units resets 00h or 08h
// - packet switching and reject snoop flags always read zero
// - each map bit n routes traffic class n to this channel
// - map bit 0 of channel one is read only zero
// - traffic class map resets 00h, management may replace it
// - writing one to load bit applies the table; reads zero
// - arbitration select accepts 000b, 011b, 100b, else 000b
// - channel identifier resets 0 or 1 by channel count strap
// - control bit 31 enables channel one, resets zero
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "vc_resource_consts.vh"

module vc_resource_registers (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] ext_channel_count,
  input wire negotiation_pending,
  input wire arb_table_written,
  output reg [7:0] traffic_class_channel_map,
  output reg [2:0] port_arb_select,
  output reg [2:0] channel_identifier,
  output reg channel_enable,
  output reg table_load_active,
  output reg [7:0] arb_capability,
  output reg [6:0] max_time_slots,
  output reg [7:0] table_offset
);

  localparam ST_IDLE = 2'b01;
  localparam ST_LOAD = 2'b10;

  reg [1:0] state_r;
  reg [7:0] load_cnt_r;
  reg table_status_r;
  reg neg_s1_r;
  reg neg_s2_r;
  reg neg_s3_r;
  reg neg_pending_r;
  reg strap_taken_r;
  reg [11:0] awaddr_r;
  reg aw_held_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_held_r;
  reg [31:0] ctrl_rd;
  reg [31:0] cap_rd;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  wire strap_on;
  wire do_write;
  wire load_req;
  wire load_done;
  wire [31:0] wd;
  wire [11:0] aw_word;
  wire [11:0] ar_word;

  // merge byte enables into old register value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  function [2:0] legal_sel;
    input [2:0] v;
    begin
      if (v == `ARB_SEL_WRR || v == `ARB_SEL_TIME_WRR)
        legal_sel = v;
      else
        legal_sel = `ARB_SEL_FIXED;
    end
  endfunction

  assign strap_on = (ext_channel_count == 3'h1);
  assign aw_word = {awaddr_r[11:2], 2'b00};
  assign ar_word = {s_axi_araddr[11:2], 2'b00};
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wd = merge(ctrl_rd, wdata_r, wstrb_r);
  assign load_req = do_write && aw_word == `OFS_CH1_CTRL
    && wstrb_r[2] && wdata_r[`BIT_LOAD_TABLE];
  assign load_done = (state_r == ST_LOAD) && (load_cnt_r == 8'h01);

  // write channel capture
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @*
  begin
    case (aw_word)
      `OFS_CH0_STATUS: wr_hit = 1'b1;
      `OFS_CH1_CAP: wr_hit = 1'b1;
      `OFS_CH1_CTRL: wr_hit = 1'b1;
      `OFS_MGMT_DEFAULTS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // control register fields
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_taken_r <= 1'b0;
      traffic_class_channel_map <= `TC_MAP_RESET;
      port_arb_select <= `ARB_SEL_FIXED;
      channel_identifier <= `CHAN_ID_OFF;
      channel_enable <= 1'b0;
      arb_capability <= `CAP_ARB_CH_OFF;
      max_time_slots <= `CAP_SLOTS_CH_OFF;
      table_offset <= `CAP_TBL_OFS_OFF;
    end
    else if (!strap_taken_r)
    begin
      strap_taken_r <= 1'b1;
      arb_capability <= strap_on ? `CAP_ARB_CH_ON : `CAP_ARB_CH_OFF;
      max_time_slots <= strap_on ? `CAP_SLOTS_CH_ON : `CAP_SLOTS_CH_OFF;
      table_offset <= strap_on ? `CAP_TBL_OFS_ON : `CAP_TBL_OFS_OFF;
      channel_identifier <= strap_on ? `CHAN_ID_ON : `CHAN_ID_OFF;
    end
    else if (do_write && aw_word == `OFS_CH1_CTRL)
    begin
      // map write, bit 0 forced zero
      traffic_class_channel_map <= {wd[7:1], 1'b0};
      port_arb_select <= legal_sel(wd[19:17]);
      channel_identifier <= wd[26:24];
      channel_enable <= wd[`BIT_CH_ENABLE];
    end
    else if (do_write && aw_word == `OFS_MGMT_DEFAULTS)
    begin
      if (wstrb_r[0])
        traffic_class_channel_map <= {wdata_r[7:1], 1'b0};
      if (wstrb_r[2])
        max_time_slots <= wdata_r[22:16];
    end
  end

  // table load sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      load_cnt_r <= 8'h00;
      table_load_active <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (load_req)
          begin
            state_r <= ST_LOAD;
            load_cnt_r <= `LOAD_CYCLES;
            table_load_active <= 1'b1;
          end
        end
        ST_LOAD:
        begin
          load_cnt_r <= load_cnt_r - 8'h01;
          if (load_done)
          begin
            state_r <= ST_IDLE;
            table_load_active <= 1'b0;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          table_load_active <= 1'b0;
        end
      endcase
    end
  end

  // status flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      table_status_r <= 1'b0;
      neg_s1_r <= 1'b0;
      neg_s2_r <= 1'b0;
      neg_s3_r <= 1'b0;
      neg_pending_r <= 1'b0;
    end
    else
    begin
      // set on table write wins over clear
      if (arb_table_written)
        table_status_r <= 1'b1;
      else if (load_done)
        table_status_r <= 1'b0;
      neg_s1_r <= negotiation_pending;
      neg_s2_r <= neg_s1_r;
      neg_s3_r <= neg_s2_r;
      if (neg_s2_r == neg_s3_r)
        neg_pending_r <= neg_s3_r;
    end
  end

  always @*
  begin
    cap_rd = 32'h0000_0000;
    cap_rd[7:0] = arb_capability;
    // flags 14 and 15 stay zero
    cap_rd[22:16] = max_time_slots;
    cap_rd[31:24] = table_offset;
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[7:0] = traffic_class_channel_map;
    ctrl_rd[19:17] = port_arb_select;
    ctrl_rd[26:24] = channel_identifier;
    ctrl_rd[`BIT_CH_ENABLE] = channel_enable;
  end

  always @*
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ar_word)
      `OFS_CH0_STATUS:
      begin
        rd_word[`BIT_TABLE_STATUS] = table_status_r;
        rd_word[`BIT_NEG_PENDING] = neg_pending_r;
      end
      `OFS_CH1_CAP: rd_word = cap_rd;
      `OFS_CH1_CTRL: rd_word = ctrl_rd;
      `OFS_MGMT_CTRL: rd_word[0] = table_load_active;
      `OFS_MGMT_DEFAULTS: rd_word = {9'h000, max_time_slots,
        8'h00, traffic_class_channel_map};
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // vc_resource_registers
